// [verilog/msd_consts.svh]
// Offsets, field positions, reset values and counts of the stream engine.
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH
`define MSD_NUM_STREAMS 8
`define MSD_NUM_CHANNELS 8
`define MSD_FIFO_DEPTH 32
`define MSD_ITEM_MAX 16'hFFFF
`define MSD_ADDR_STATUS 9'h000
`define MSD_STREAM_BASE 9'h020
`define MSD_STREAM_STRIDE 9'h020
`define MSD_REG_CTRL 3'h0
`define MSD_REG_ITEMS 3'h1
`define MSD_REG_PADDR 3'h2
`define MSD_REG_MADDR0 3'h3
`define MSD_REG_MADDR1 3'h4
`define MSD_CR_EN 0
`define MSD_CR_DIR_LO 6
`define MSD_CR_SIZE_LO 11
`define MSD_CR_PL_LO 16
`define MSD_CR_DBM 18
`define MSD_CR_CT 19
`define MSD_CR_REQUEST_CHANNEL_SELECT_LO 25
`define MSD_CR_MASK 32'h0E0F_18C1
`define MSD_CTRL_RESET 32'h0000_0000
`define MSD_FULL_STRB 4'hF
`endif

// [verilog/msd_pkg.sv]
// Types shared by the stream engine modules.
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_DIR_P2M = 2'h0,
    MSD_DIR_M2P = 2'h1,
    MSD_DIR_M2M = 2'h2,
    MSD_DIR_RSV = 2'h3
  } msd_dir_t;
  typedef enum logic [3:0] {
    MSD_ST_IDLE = 4'h1,
    MSD_ST_READ = 4'h2,
    MSD_ST_PUSH = 4'h4,
    MSD_ST_WRITE = 4'h8
  } msd_state_t;
endpackage

// [verilog/msd_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module msd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic in_valid, // Write side offers a word.
  output logic in_ready, // FIFO has room.
  input wire logic [WIDTH-1:0] in_data, // Word to store.
  output logic out_valid, // FIFO holds a word.
  input wire logic out_ready, // Read side takes the word.
  output logic [WIDTH-1:0] out_data // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [verilog/msd_arbiter.sv]
// Fixed two-stage arbiter: software level first, then lowest stream index.
`timescale 1ns/10ps
module msd_arbiter #(
  parameter int N = 8
) (
  input wire logic [N-1:0] req, // Stream requests for this port.
  input wire logic [2*N-1:0] level, // Two-bit priority per stream, 3 is highest.
  output logic win_valid, // Some stream requests.
  output logic [$clog2(N)-1:0] win_idx // Winning stream.
);
  localparam int IW = $clog2(N);
  logic [1:0] best;

  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    best = 2'h0;
    // Scanning downward with >= lets the lower index win a tie.
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!win_valid || level[2*i +: 2] >= best)) begin
        win_valid = 1'b1;
        win_idx = IW'(i);
        best = level[2*i +: 2];
      end
    end
  end
endmodule

// [verilog/msd_dma_core.sv]
// Eight-stream transfer engine with APB programming port and two master ports.
//
// Contract
// - Moves peripheral-memory, memory-peripheral, memory-memory.
// - Memory and peripheral masters; peripheral reaches memory.
// - Programming port accepts full 32-bit words only.
// - Software sets item count and item width.
// - Read source, write destination, decrement count.
// - Serve by priority, acknowledge on peripheral access.
// - Acknowledge falls only after request falls.
// - Three-bit select picks one of eight channels.
// - Channel-to-peripheral wiring fixed at integration.
// - Per-port arbiter picks stream, starts access.
// - Four software levels, higher preferred.
// - Equal levels: lowest stream index wins.
// - Each stream moves data one way only.
// - Optional double buffer with two memory pointers.
// - Item count up to 65535, decremented.
// - Memory-to-memory only on second controller instance.
// - Direction field 00, 01, 10; 11 reserved.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "msd_consts.svh"
module msd_dma_core
  import msd_pkg::*;
#(
  parameter bit SECOND_CONTROLLER = 1'b1,
  parameter logic [63:0] CHANNEL_CONNECTED = 64'hFFFF_FFFF_FFFF_FFFF,
  parameter int FIFO_DEPTH = `MSD_FIFO_DEPTH
) (
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error.
  input wire logic [63:0] periph_req, // Channel requests, stream*8+channel.
  output logic [63:0] periph_ack, // Acknowledge, stream*8+channel.
  output logic mem_req, // Memory port access request.
  output logic mem_write, // Memory port write.
  output logic [31:0] mem_addr, // Memory port address.
  output logic [1:0] mem_size, // Item width: 0 byte, 1 half, 2 word.
  output logic [31:0] mem_wdata, // Memory port write data.
  input wire logic mem_ready, // Memory port access done.
  input wire logic [31:0] mem_rdata, // Memory port read data.
  output logic per_req, // Peripheral port access request.
  output logic per_write, // Peripheral port write.
  output logic [31:0] per_addr, // Peripheral port address.
  output logic [1:0] per_size, // Item width.
  output logic [31:0] per_wdata, // Peripheral port write data.
  input wire logic per_ready, // Peripheral port access done.
  input wire logic [31:0] per_rdata // Peripheral port read data.
);
  localparam int NS = `MSD_NUM_STREAMS;
  localparam int NC = `MSD_NUM_CHANNELS;

  logic [31:0] ctrl_ff [NS];
  logic [15:0] items_ff [NS];
  logic [15:0] reload_ff [NS];
  logic [31:0] paddr_ff [NS];
  logic [31:0] maddr0_ff [NS];
  logic [31:0] maddr1_ff [NS];
  logic [NS-1:0] ack_ff;
  msd_state_t state_ff;
  logic [2:0] cur_ff;
  logic src_per_ff;
  logic last_per_ff;
  logic [31:0] data_ff;

  function automatic msd_dir_t dir_of(input logic [31:0] cr);
    return msd_dir_t'(cr[`MSD_CR_DIR_LO +: 2]);
  endfunction

  function automatic logic [31:0] mem_ptr(input int s);
    return ctrl_ff[s][`MSD_CR_CT] ? maddr1_ff[s] : maddr0_ff[s];
  endfunction

  // APB decode: stream index and register slot.
  logic wr_en;
  logic acc;
  logic hit_stream;
  logic [3:0] blk;
  logic [2:0] sid;
  logic [2:0] slot;
  logic bad;
  assign acc = psel && penable;
  assign blk = paddr[8:5];
  assign sid = 3'(blk - 4'h1);
  assign slot = paddr[4:2];
  assign hit_stream = (paddr[11:9] == 3'h0) && (blk != 4'h0) && (slot <= `MSD_REG_MADDR1)
                      && (paddr[1:0] == 2'h0) && (blk <= 4'(NS));
  always_comb begin
    bad = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      bad = 1'b1;
    end else if (pwrite && pstrb != `MSD_FULL_STRB) begin
      bad = 1'b1;
    end else if (!hit_stream && paddr[11:0] != {3'h0, `MSD_ADDR_STATUS}) begin
      bad = 1'b1;
    end else if (!hit_stream && pwrite) begin
      bad = 1'b1;
    end
  end
  assign pready = 1'b1;
  assign pslverr = acc && bad;
  assign wr_en = acc && pwrite && !bad && hit_stream;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit_stream && slot == `MSD_REG_CTRL) begin
        prdata <= ctrl_ff[sid];
      end else if (hit_stream && slot == `MSD_REG_ITEMS) begin
        prdata <= {16'h0000, items_ff[sid]};
      end else if (hit_stream && slot == `MSD_REG_PADDR) begin
        prdata <= paddr_ff[sid];
      end else if (hit_stream && slot == `MSD_REG_MADDR0) begin
        prdata <= maddr0_ff[sid];
      end else if (hit_stream && slot == `MSD_REG_MADDR1) begin
        prdata <= maddr1_ff[sid];
      end else if (paddr[11:0] == {3'h0, `MSD_ADDR_STATUS}) begin
        prdata <= {16'h0000, ack_ff, 1'b0, cur_ff, state_ff};
      end
    end
  end

  // Selected channel request per stream.
  logic [NS-1:0] sel_req;
  logic [NS-1:0] per_need;
  logic [NS-1:0] mem_need;
  logic [2*NS-1:0] levels;
  logic per_win_v;
  logic mem_win_v;
  logic [2:0] per_win;
  logic [2:0] mem_win;
  logic [NS-1:0] live;
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      sel_req[s] = periph_req[s*NC + ctrl_ff[s][`MSD_CR_REQUEST_CHANNEL_SELECT_LO +: 3]]
                   && CHANNEL_CONNECTED[s*NC + ctrl_ff[s][`MSD_CR_REQUEST_CHANNEL_SELECT_LO +: 3]];
      live[s] = ctrl_ff[s][`MSD_CR_EN] && items_ff[s] != 16'h0000
                && !(state_ff != MSD_ST_IDLE && cur_ff == 3'(s));
      // no new service while acknowledge held
      per_need[s] = live[s] && ((dir_of(ctrl_ff[s]) == MSD_DIR_P2M && sel_req[s] && !ack_ff[s])
                    || (dir_of(ctrl_ff[s]) == MSD_DIR_M2M && SECOND_CONTROLLER));
      mem_need[s] = live[s] && dir_of(ctrl_ff[s]) == MSD_DIR_M2P && sel_req[s] && !ack_ff[s];
      levels[2*s +: 2] = ctrl_ff[s][`MSD_CR_PL_LO +: 2];
    end
  end

  msd_arbiter #(.N(NS)) u_per_arb (
    .req(per_need),
    .level(levels),
    .win_valid(per_win_v),
    .win_idx(per_win)
  );
  msd_arbiter #(.N(NS)) u_mem_arb (
    .req(mem_need),
    .level(levels),
    .win_valid(mem_win_v),
    .win_idx(mem_win)
  );

  // Data FIFO between the read and write halves of a transfer.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic dst_per;
  logic dst_ready;
  logic wr_done;
  logic rd_done;
  assign dst_per = (dir_of(ctrl_ff[cur_ff]) == MSD_DIR_M2P);
  assign dst_ready = dst_per ? per_ready : mem_ready;
  assign wr_done = state_ff == MSD_ST_WRITE && fifo_out_valid && dst_ready;
  assign rd_done = state_ff == MSD_ST_READ && (src_per_ff ? per_ready : mem_ready);

  msd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(state_ff == MSD_ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(data_ff),
    .out_valid(fifo_out_valid),
    .out_ready(wr_done),
    .out_data(fifo_out_data)
  );

  // Sequencer; ports alternate when both have a winner so neither starves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MSD_ST_IDLE;
      cur_ff <= 3'h0;
      src_per_ff <= 1'b0;
      last_per_ff <= 1'b0;
      data_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        MSD_ST_IDLE: begin
          if (per_win_v && (!mem_win_v || !last_per_ff)) begin
            cur_ff <= per_win;
            src_per_ff <= 1'b1;
            last_per_ff <= 1'b1;
            state_ff <= MSD_ST_READ;
          end else if (mem_win_v) begin
            cur_ff <= mem_win;
            src_per_ff <= 1'b0;
            last_per_ff <= 1'b0;
            state_ff <= MSD_ST_READ;
          end
        end
        MSD_ST_READ: begin
          if (rd_done) begin
            data_ff <= src_per_ff ? per_rdata : mem_rdata;
            state_ff <= MSD_ST_PUSH;
          end
        end
        MSD_ST_PUSH: begin
          if (fifo_in_ready) begin
            state_ff <= MSD_ST_WRITE;
          end
        end
        MSD_ST_WRITE: begin
          if (wr_done) begin
            state_ff <= MSD_ST_IDLE;
          end
        end
        default: begin
          state_ff <= MSD_ST_IDLE;
        end
      endcase
    end
  end

  // source on read, destination on write
  // peripheral port reads memory in memory-to-memory
  always_comb begin
    mem_req = 1'b0;
    mem_write = 1'b0;
    mem_addr = mem_ptr(int'(cur_ff));
    mem_wdata = fifo_out_data;
    per_req = 1'b0;
    per_write = 1'b0;
    per_addr = paddr_ff[cur_ff];
    per_wdata = fifo_out_data;
    if (state_ff == MSD_ST_READ) begin
      per_req = src_per_ff;
      mem_req = !src_per_ff;
    end else if (state_ff == MSD_ST_WRITE && fifo_out_valid) begin
      per_req = dst_per;
      per_write = dst_per;
      mem_req = !dst_per;
      mem_write = !dst_per;
    end
  end
  assign mem_size = ctrl_ff[cur_ff][`MSD_CR_SIZE_LO +: 2];
  assign per_size = ctrl_ff[cur_ff][`MSD_CR_SIZE_LO +: 2];

  // Acknowledge: raised at the peripheral access, dropped once request is gone.
  logic per_access;
  assign per_access = (rd_done && src_per_ff && dir_of(ctrl_ff[cur_ff]) == MSD_DIR_P2M)
                      || (wr_done && dst_per);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= '0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (per_access && cur_ff == 3'(s)) begin
          ack_ff[s] <= 1'b1;
        end else if (ack_ff[s] && !sel_req[s]) begin
          ack_ff[s] <= 1'b0;
        end
      end
    end
  end
  always_comb begin
    periph_ack = '0;
    for (int s = 0; s < NS; s++) begin
      periph_ack[s*NC + ctrl_ff[s][`MSD_CR_REQUEST_CHANNEL_SELECT_LO +: 3]] = ack_ff[s];
    end
  end

  // Stream registers; hardware completion beats a same-cycle software write
  // only for the count, so a fresh enable from software is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NS; s++) begin
        ctrl_ff[s] <= `MSD_CTRL_RESET;
        items_ff[s] <= 16'h0000;
        reload_ff[s] <= 16'h0000;
        paddr_ff[s] <= 32'h0000_0000;
        maddr0_ff[s] <= 32'h0000_0000;
        maddr1_ff[s] <= 32'h0000_0000;
      end
    end else begin
      if (wr_done) begin
        // swap buffer and reload at end
        if (items_ff[cur_ff] == 16'h0001 && ctrl_ff[cur_ff][`MSD_CR_DBM]) begin
          items_ff[cur_ff] <= reload_ff[cur_ff];
          ctrl_ff[cur_ff][`MSD_CR_CT] <= !ctrl_ff[cur_ff][`MSD_CR_CT];
        end else begin
          items_ff[cur_ff] <= items_ff[cur_ff] - 16'h0001;
          if (items_ff[cur_ff] == 16'h0001) begin
            ctrl_ff[cur_ff][`MSD_CR_EN] <= 1'b0;
          end
        end
      end
      if (wr_en) begin
        if (slot == `MSD_REG_CTRL) begin
          ctrl_ff[sid] <= pwdata & `MSD_CR_MASK;
        end else if (slot == `MSD_REG_ITEMS && !(wr_done && cur_ff == sid)) begin
          items_ff[sid] <= pwdata[15:0];
          reload_ff[sid] <= pwdata[15:0];
        end else if (slot == `MSD_REG_PADDR) begin
          paddr_ff[sid] <= pwdata;
        end else if (slot == `MSD_REG_MADDR0) begin
          maddr0_ff[sid] <= pwdata;
        end else if (slot == `MSD_REG_MADDR1) begin
          maddr1_ff[sid] <= pwdata;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_done;
    state_ff == MSD_ST_READ && (src_per_ff ? per_ready : mem_ready);
  endsequence
  sequence s_push_then_write;
    state_ff == MSD_ST_PUSH ##[1:40] state_ff == MSD_ST_WRITE;
  endsequence

  a_word_only: assert property (acc && pwrite && pstrb != `MSD_FULL_STRB |-> pslverr)
    else $error("partial write not refused");
  a_read_to_push: assert property (s_read_done |=> s_push_then_write)
    else $error("read not followed by push and write");
  a_count_dec: assert property (wr_done && items_ff[cur_ff] > 16'h0001
    |=> items_ff[$past(cur_ff)] == $past(items_ff[cur_ff]) - 16'h0001)
    else $error("item count not decremented");
  a_ack_hold: assert property (ack_ff[cur_ff] && sel_req[cur_ff] && !per_access
    |=> ack_ff[$past(cur_ff)])
    else $error("acknowledge dropped while request high");
  a_ack_raise: assert property (per_access |=> ack_ff[$past(cur_ff)])
    else $error("acknowledge missing after peripheral access");
  a_no_reserved: assert property (state_ff == MSD_ST_READ
    |-> dir_of(ctrl_ff[cur_ff]) != MSD_DIR_RSV)
    else $error("reserved direction started");
  a_m2m_first: assert property (!SECOND_CONTROLLER && state_ff == MSD_ST_READ
    |-> dir_of(ctrl_ff[cur_ff]) != MSD_DIR_M2M)
    else $error("memory copy on first controller");
  a_arb_level: assert property (per_win_v && per_need[5]
    |-> levels[2*per_win +: 2] >= levels[11:10])
    else $error("lower level beat stream five");
  a_tie_low: assert property (per_need[3] && per_need[6]
    && levels[7:6] == levels[13:12] |-> per_win != 3'h6)
    else $error("tie not given to lower index");
  a_unconn: assert property (!CHANNEL_CONNECTED[{3'h7,
    ctrl_ff[7][`MSD_CR_REQUEST_CHANNEL_SELECT_LO +: 3]}] |-> !sel_req[7])
    else $error("unconnected channel triggered");
endmodule

// [test/msd_tb_partner.sv]
// Far-side models: a bus slave with adjustable wait states and a bank of requesting peripherals.
`timescale 1ns/10ps
module msd_tb_slave (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic req, // Access request from the engine.
  input wire logic write, // Access is a write.
  input wire logic [31:0] addr, // Access address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] dly, // Wait states before ready.
  output logic ready, // Access completes.
  output logic [31:0] rdata // Read data.
);
  logic [3:0] cnt_ff;
  logic [31:0] last_ff;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wr_log [$];
  assign ready = req && (cnt_ff == dly);
  // Outside a completing access the data lines carry the inverse of the last value, never a
  // stale copy that a careless sampler could mistake for fresh data.
  always @* begin
    if (ready && !write) begin
      rdata = mem.exists(addr) ? mem[addr] : ~addr;
    end else begin
      rdata = ~last_ff;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      last_ff <= 32'h0000_0000;
    end else if (ready) begin
      cnt_ff <= 4'h0;
      last_ff <= write ? wdata : rdata;
      if (write) begin
        mem[addr] = wdata;
        wr_log.push_back(addr);
      end
    end else if (req) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

module msd_tb_requester (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [63:0] want, // Bench wants service on this line.
  input wire logic [63:0] ack, // Acknowledge from the engine.
  output logic [63:0] req, // Request lines to the engine.
  output logic proto_err // Acknowledge fell while its request was still up.
);
  logic [63:0] ack_q;
  logic [63:0] req_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 64'h0000_0000_0000_0000;
      ack_q <= 64'h0000_0000_0000_0000;
      req_q <= 64'h0000_0000_0000_0000;
      proto_err <= 1'b0;
    end else begin
      ack_q <= ack;
      req_q <= req;
      // drop on acknowledge, re-raise only after handshake.
      req <= (req & ~ack) | (want & ~ack & ~req);
      if (|(ack_q & ~ack & req_q)) begin
        proto_err <= 1'b1;
      end
    end
  end
endmodule

// [test/test_msd_dma_core.sv]
// Self-checking bench for the stream engine: APB programming and transfers through the models.
`timescale 1ns/10ps
`include "msd_consts.svh"
module test_msd_dma_core;
  import msd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, per_addr, per_wdata, per_rdata, rd;
  logic pready, pslverr, mem_req, mem_write, mem_ready, per_req, per_write, per_ready;
  logic proto_err, er;
  logic [63:0] periph_req, periph_ack;
  logic [63:0] want = 64'h0000_0000_0000_0000;
  logic [1:0] mem_size, per_size;
  logic [3:0] mem_dly = 4'h0;
  logic [3:0] per_dly = 4'h0;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int hi [2] = '{5, 3};
  int lo [2] = '{4, 6};
  logic [11:0] bad [3] = '{12'h022, 12'h200, 12'h000};

  always #5 pclk = ~pclk;

  // Stream 7 channel 7 is left unwired to show that an empty channel never fires.
  msd_dma_core #(.CHANNEL_CONNECTED(64'h7FFF_FFFF_FFFF_FFFF)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .periph_ack(periph_ack),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .per_req(per_req), .per_write(per_write), .per_addr(per_addr), .per_size(per_size),
    .per_wdata(per_wdata), .per_ready(per_ready), .per_rdata(per_rdata));
  msd_tb_slave i_mem (.pclk(pclk), .presetn(presetn), .req(mem_req), .write(mem_write),
    .addr(mem_addr), .wdata(mem_wdata), .dly(mem_dly), .ready(mem_ready), .rdata(mem_rdata));
  msd_tb_slave i_per (.pclk(pclk), .presetn(presetn), .req(per_req), .write(per_write),
    .addr(per_addr), .wdata(per_wdata), .dly(per_dly), .ready(per_ready), .rdata(per_rdata));
  msd_tb_requester i_periph (.pclk(pclk), .presetn(presetn), .want(want), .ack(periph_ack),
    .req(periph_req), .proto_err(proto_err));

  function automatic logic [11:0] ra(int s, int r);
    return 12'(`MSD_STREAM_BASE + s * `MSD_STREAM_STRIDE + r * 4);
  endfunction
  function automatic logic [31:0] ma(int s);
    return 32'h2000_0000 + 32'(s) * 32'h0000_0100;
  endfunction
  function automatic logic [31:0] pa(int s);
    return 32'h4000_0000 + 32'(s) * 32'h0000_0004;
  endfunction
  function automatic logic [31:0] cr(msd_dir_t d, int pl, int ch, int dbm);
    return (32'h0000_0001 << `MSD_CR_EN) | (32'(d) << `MSD_CR_DIR_LO)
      | (32'h0000_0002 << `MSD_CR_SIZE_LO) | (32'(pl) << `MSD_CR_PL_LO)
      | (32'(dbm) << `MSD_CR_DBM) | (32'(ch) << `MSD_CR_REQUEST_CHANNEL_SELECT_LO);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Count and addresses go in before the control word, since that write enables the stream.
  task automatic cfg(input int s, input logic [31:0] n, input logic [31:0] c);
    apb(1'b1, ra(s, `MSD_REG_ITEMS), n, 4'hF);
    apb(1'b1, ra(s, `MSD_REG_PADDR), pa(s), 4'hF);
    apb(1'b1, ra(s, `MSD_REG_MADDR0), ma(s), 4'hF);
    apb(1'b1, ra(s, `MSD_REG_MADDR1), ma(s) + 32'h0000_0080, 4'hF);
    apb(1'b0, ra(s, `MSD_REG_PADDR), 32'h0000_0000, 4'hF);
    chk_word(rd, pa(s));
    apb(1'b1, ra(s, `MSD_REG_CTRL), c, 4'hF);
  endtask

  // Only the bench timeout ends this wait if it hangs, so a hang is counted as a mismatch.
  task automatic wait_log(input int n);
    while (i_mem.wr_log.size() < n) begin
      @(posedge pclk);
    end
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ra(0, `MSD_REG_CTRL), 32'hFFFF_FFFF, 4'h3);
    chk_flag(er, 1'b1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, bad[i], 32'hFFFF_FFFF, 4'hF);
      chk_flag(er, 1'b1);
    end
    apb(1'b0, 12'h200, 32'h0000_0000, 4'hF);
    chk_flag(er, 1'b1);
    for (int s = 0; s < 8; s++) begin
      apb(1'b0, ra(s, `MSD_REG_CTRL), 32'h0000_0000, 4'hF);
      chk_word(rd, `MSD_CTRL_RESET);
    end
    // Two items from the peripheral into memory on channel 3, each after its own request handshake.
    cfg(0, 32'h0000_0002, cr(MSD_DIR_P2M, 0, 3, 0));
    want[3] <= 1'b1;
    wait_log(2);
    want[3] <= 1'b0;
    chk_word(i_mem.wr_log[1], ma(0));
    chk_word(i_mem.mem[ma(0)], ~pa(0));
    apb(1'b0, ra(0, `MSD_REG_ITEMS), 32'h0000_0000, 4'hF);
    chk_word(rd & 32'h0000_FFFF, 32'h0000_0000);
    apb(1'b0, ra(0, `MSD_REG_CTRL), 32'h0000_0000, 4'hF);
    chk_flag(rd[`MSD_CR_EN], 1'b0);
    // Memory to peripheral with slow slaves on both ports.
    per_dly <= 4'h3;
    mem_dly <= 4'h2;
    cfg(1, 32'h0000_0001, cr(MSD_DIR_M2P, 0, 0, 0));
    want[8] <= 1'b1;
    wait_log(2);
    repeat (40) @(posedge pclk);
    want[8] <= 1'b0;
    per_dly <= 4'h0;
    mem_dly <= 4'h0;
    chk_word(i_per.wr_log[0], pa(1));
    chk_word(i_per.mem[pa(1)], ~ma(1));
    chk_word({28'h0000_000, mem_size, per_size}, 32'h0000_000A);
    cfg(2, 32'h0000_0001, cr(MSD_DIR_M2M, 0, 0, 0));
    wait_log(3);
    chk_word(i_mem.mem[ma(2)], ~pa(2));
    // Higher level first, then the lower index among equal levels.
    for (int i = 0; i < 2; i++) begin
      cfg(lo[i], 32'h0000_0001, cr(MSD_DIR_P2M, i * 2, 1, 0));
      cfg(hi[i], 32'h0000_0001, cr(MSD_DIR_P2M, 3 - i, 1, 0));
      want[lo[i] * 8 + 1] <= 1'b1;
      want[hi[i] * 8 + 1] <= 1'b1;
      wait_log(5 + 2 * i);
      chk_word(i_mem.wr_log[3 + 2 * i], ma(hi[i]));
      chk_word(i_mem.wr_log[4 + 2 * i], ma(lo[i]));
    end
    want <= 64'h0000_0000_0000_0000;
    cfg(7, 32'h0000_0001, cr(MSD_DIR_P2M, 0, 7, 0));
    want[63] <= 1'b1;
    repeat (60) @(posedge pclk);
    chk_word(32'(i_mem.wr_log.size()), 32'h0000_0007);
    apb(1'b0, ra(7, `MSD_REG_ITEMS), 32'h0000_0000, 4'hF);
    chk_word(rd & 32'h0000_FFFF, 32'h0000_0001);
    // Double buffer: one item per buffer, the second lands in the other pointer.
    cfg(0, 32'h0000_0001, cr(MSD_DIR_P2M, 0, 2, 1));
    want[2] <= 1'b1;
    wait_log(9);
    want[2] <= 1'b0;
    // Let any last handshake finish before the channel select moves the acknowledge.
    repeat (10) @(posedge pclk);
    apb(1'b1, ra(0, `MSD_REG_CTRL), 32'h0000_0000, 4'hF);
    chk_word(i_mem.wr_log[7], ma(0));
    chk_word(i_mem.wr_log[8], ma(0) + 32'h0000_0080);
    chk_flag(proto_err, 1'b0);
    end_of_test();
  end
endmodule
